// File: design/ilhp_pkg.sv
// Package: shared constants and types of the display host port link
`default_nettype none
package ilhp_pkg;
  // ****************************************************************
  // Widths and window
  // ****************************************************************
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam logic [31:0] WIN_BYTES = 32'h0002_0000;
  localparam logic [31:0] WIN_BASE = 32'h133E_0000;
  localparam logic [31:0] WIN_LAST = 32'h133F_FFFF;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_DIV = 8;
  localparam logic [3:0] LINK_DIV_LAST = 4'h7;
  // Ready low needs five cycles to cross both sync chains back to the host
  localparam logic [3:0] BUS_WAIT_CYCLES = 4'h5;
  localparam logic [7:0] HOST_TIMEOUT = 8'hFF;
  // ****************************************************************
  // Reset values and strap code for the generic 16-bit mode
  // ****************************************************************
  localparam logic [3:0] STRAP_GENERIC16 = 4'hF;
  localparam logic [3:0] STRAP_RESET = 4'h0;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  typedef enum logic [1:0] {ILHP_OP_NONE, ILHP_OP_READ, ILHP_OP_WRITE} ilhp_op_t;
endpackage
`default_nettype wire

// File: design/ilhp_if.sv
// Interface: ISA-style display port wires between host and controller
`default_nettype none
interface ilhp_if;
  logic [16:0] addr;
  logic [15:0] data_host;
  logic data_host_oe;
  logic [15:0] data_dev;
  logic data_dev_oe;
  logic display_controller_select_n;
  logic memory_read_strobe_n;
  logic memory_write_strobe_n;
  logic upper_byte_enable_n;
  logic wide_transfer_ack_n;
  logic ready;
  logic link_clk;
  logic [15:0] data_bus;
  // Resolved data wire; floating bus reads as all ones
  assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : 16'hFFFF);
  modport host (
    output addr, data_host, data_host_oe, display_controller_select_n,
    output memory_read_strobe_n, memory_write_strobe_n, upper_byte_enable_n, link_clk,
    input data_bus, wide_transfer_ack_n, ready
  );
  modport dev (
    input addr, data_bus, display_controller_select_n, link_clk,
    input memory_read_strobe_n, memory_write_strobe_n, upper_byte_enable_n,
    output data_dev, data_dev_oe, wide_transfer_ack_n, ready
  );
endinterface
`default_nettype wire

// File: design/ilhp_dev.sv
// Controller end: decodes select and strobes, stretches cycles, moves data to the user
`default_nettype none
module ilhp_dev (
  input wire logic mclk_i,
  input wire logic nrst_i,
  ilhp_if.dev bus,
  input wire logic [3:0] strap_i,
  input wire logic bus_status_strap_n_i,
  output logic generic16_o,
  output logic [16:0] user_addr_o,
  output logic [15:0] user_wdata_o,
  output logic [1:0] user_lane_o,
  output logic user_wr_o,
  output logic user_rd_o,
  input wire logic user_ack_i,
  input wire logic [15:0] user_rdata_i
);
  // ****************************************************************
  // Pin synchronisers: two flops before any logic
  // ****************************************************************
  logic [4:0] ctl_s1, ctl_s2;
  logic [16:0] addr_s1, addr_s2;
  logic [15:0] data_s1, data_s2;
  logic strap_done;
  logic [16:0] user_addr;
  logic [15:0] user_wdata, rdata;
  logic [1:0] user_lane;
  logic user_wr, user_rd, ready, drive, generic16;
  logic [4:0] strap_s1, strap_s2;
  logic link_prev, wack_n;
  typedef enum logic [1:0] {DEV_IDLE, DEV_WAIT, DEV_HOLD, DEV_DONE} ilhp_dev_state_t;
  ilhp_dev_state_t state;
  // Address and data settle a cycle before the strobes, so each word is
  // steady by the time its strobe leaves the chain
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctl_s1 <= 5'h0F;  // Bus clock bit idles low: no false edge
      ctl_s2 <= 5'h0F;
      addr_s1 <= 17'h00000;
      addr_s2 <= 17'h00000;
      data_s1 <= 16'h0000;
      data_s2 <= 16'h0000;
    end
    else
    begin
      ctl_s1 <= {bus.link_clk, bus.display_controller_select_n, bus.memory_read_strobe_n,
                 bus.memory_write_strobe_n, bus.upper_byte_enable_n};
      ctl_s2 <= ctl_s1;
      addr_s1 <= bus.addr;
      addr_s2 <= addr_s1;
      data_s1 <= bus.data_bus;
      data_s2 <= data_s1;
    end
  end
  // ****************************************************************
  // Strap synchronisers
  // ****************************************************************
  // Straps are pins too; no reset here, so the chain carries the level
  // held during reset straight into the capture at release.
  // Straps must be steady for two cycles before reset rises.
  always_ff @(posedge mclk_i)
  begin
    strap_s1 <= {bus_status_strap_n_i, strap_i};
    strap_s2 <= strap_s1;
  end
  // ****************************************************************
  // Decode of synchronised strobes
  // ****************************************************************
  // Only the 17 offset bits reach us; select qualifies the window
  wire sel = !ctl_s2[3];
  // A strobe counts only under select
  wire rd_req = sel && !ctl_s2[2];
  wire wr_req = sel && !ctl_s2[1];
  wire hi_lane = !ctl_s2[0];
  // Lower lane for even addresses and for every byte-wide cycle
  wire low_lane = !addr_s2[0] || !hi_lane;
  wire any_req = rd_req || wr_req;
  // Rising edge of the host bus clock paces the end of each cycle
  wire link_rise = ctl_s2[4] && !link_prev;
  // All host bus straps and the status strap high select generic mode
  wire strap_ok = (strap_s2[3:0] == ilhp_pkg::STRAP_GENERIC16) && strap_s2[4];
  // ****************************************************************
  // Strap capture, first clocked edge after reset release
  // ****************************************************************
  // Captured once per reset; later strap motion is ignored
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      strap_done <= 1'b0;
      generic16 <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      generic16 <= strap_ok;
    end
  end
  // ****************************************************************
  // Bus clock edge finder and wide acknowledge
  // ****************************************************************
  // Acknowledge is registered so the pin never shows decode glitches;
  // the edge is found on the synchronised copy, two cycles behind the pin
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      link_prev <= 1'b0;
      wack_n <= 1'b1;
    end
    else
    begin
      link_prev <= ctl_s2[4];
      wack_n <= ~(sel && generic16);
    end
  end
  // ****************************************************************
  // Cycle controller: holds ready low until the user side answers
  // ****************************************************************
  // Ready low from the first sampled strobe until user acknowledge and
  // the next bus clock rise; the pin sync adds two cycles the host must
  // tolerate. A stopped bus clock leaves the host waiting for its timeout.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= DEV_IDLE;
      ready <= 1'b1;
      drive <= 1'b0;
      user_rd <= 1'b0;
      user_wr <= 1'b0;
      user_addr <= 17'h00000;
      user_wdata <= ilhp_pkg::DATA_RESET;
      user_lane <= 2'h0;
      rdata <= ilhp_pkg::DATA_RESET;
    end
    else
    begin
      case (state)
        DEV_IDLE:
          // An unstrapped controller leaves every access alone
          if (any_req && generic16)
          begin
            state <= DEV_WAIT;
            ready <= 1'b0;
            user_rd <= rd_req;
            user_wr <= wr_req;
            user_addr <= addr_s2;
            user_wdata <= data_s2;
            user_lane <= {hi_lane, low_lane};
          end
        DEV_WAIT:
          if (user_ack_i)
          begin
            state <= DEV_HOLD;
            user_rd <= 1'b0;
            user_wr <= 1'b0;
            rdata <= user_rdata_i;
            drive <= user_rd;  // Data settles before ready rises
          end
        DEV_HOLD:
          // Release only on a bus clock rise, so the host sees it in step
          if (link_rise)
          begin
            state <= DEV_DONE;
            ready <= 1'b1;
          end
        default:
          // Wait for the strobes to rise so one access is taken once
          if (!any_req)
          begin
            state <= DEV_IDLE;
            drive <= 1'b0;
          end
      endcase
    end
  end
  // ****************************************************************
  // Outputs, all straight from flops
  // ****************************************************************
  assign bus.ready = ready;
  assign bus.data_dev = rdata;
  assign bus.data_dev_oe = drive;
  assign bus.wide_transfer_ack_n = wack_n;
  assign generic16_o = generic16;
  assign user_addr_o = user_addr;
  assign user_wdata_o = user_wdata;
  assign user_lane_o = user_lane;
  assign user_wr_o = user_wr;
  assign user_rd_o = user_rd;
endmodule
`default_nettype wire

// File: design/ilhp_host.sv
// Host end: maps the window, runs read and write cycles, makes the bus clock
`default_nettype none
module ilhp_host (
  input wire logic mclk_i,
  input wire logic nrst_i,
  ilhp_if.host bus,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_wide_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic miss_o,
  output logic [15:0] rdata_o
);
  // ****************************************************************
  // Bus clock divider
  // ****************************************************************
  logic [3:0] div;
  logic link_clk;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div <= 4'h0;
      link_clk <= 1'b0;
    end
    else
    begin
      div <= (div == ilhp_pkg::LINK_DIV_LAST) ? 4'h0 : div + 4'h1;
      if (div == ilhp_pkg::LINK_DIV_LAST)
        link_clk <= ~link_clk;
    end
  end
  // ****************************************************************
  // Returned pins pass two flops
  // ****************************************************************
  logic [1:0] rdy_s, ack_s;
  logic [15:0] dat_s1, dat_s2;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdy_s <= 2'h3;
      ack_s <= 2'h3;
      dat_s1 <= 16'h0000;
      dat_s2 <= 16'h0000;
    end
    else
    begin
      rdy_s <= {rdy_s[0], bus.ready};
      ack_s <= {ack_s[0], bus.wide_transfer_ack_n};
      dat_s1 <= bus.data_bus;
      dat_s2 <= dat_s1;
    end
  end
  // ****************************************************************
  // Window decode
  // ****************************************************************
  wire in_win = (req_addr_i >= ilhp_pkg::WIN_BASE) && (req_addr_i <= ilhp_pkg::WIN_LAST);
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_WAIT, H_END} ilhp_host_state_t;
  ilhp_host_state_t state;
  logic [7:0] cnt;
  logic [16:0] addr;
  logic [15:0] wdata, rdata;
  logic wr, ube_n, cs_n, rd_n, wr_n, oe, busy, done, miss;
  // ****************************************************************
  // Cycle sequencer: setup, then wait for ready to return high
  // ****************************************************************
  // Minimum wait lets the device's sync chain pull ready low first
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= H_IDLE;
      cnt <= 8'h00;
      addr <= 17'h00000;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      wr <= 1'b0;
      ube_n <= 1'b1;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      oe <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      miss <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      miss <= 1'b0;
      case (state)
        H_IDLE:
          if (req_i && !in_win)
            miss <= 1'b1;
          else if (req_i)
          begin
            state <= H_SETUP;
            busy <= 1'b1;
            addr <= req_addr_i[16:0];
            wdata <= req_wdata_i;
            wr <= req_write_i;
            ube_n <= ~req_wide_i;
            cs_n <= 1'b0;
            oe <= req_write_i;
            cnt <= 8'h00;
          end
        H_SETUP:
          begin
            state <= H_WAIT;
            rd_n <= wr;
            wr_n <= ~wr;
          end
        H_WAIT:
          begin
            cnt <= cnt + 8'h01;
            if (cnt >= {4'h0, ilhp_pkg::BUS_WAIT_CYCLES} && rdy_s[1])
            begin
              state <= H_END;
              rdata <= (!ube_n && !ack_s[1]) ? dat_s2 : {8'h00, dat_s2[7:0]};
            end
            else if (cnt == ilhp_pkg::HOST_TIMEOUT)
              state <= H_END;
          end
        default:
          begin
            state <= H_IDLE;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            cs_n <= 1'b1;
            oe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
          end
      endcase
    end
  end
  assign bus.addr = addr;
  assign bus.data_host = wdata;
  assign bus.data_host_oe = oe;
  assign bus.display_controller_select_n = cs_n;
  assign bus.memory_read_strobe_n = rd_n;
  assign bus.memory_write_strobe_n = wr_n;
  assign bus.upper_byte_enable_n = ube_n;
  assign bus.link_clk = link_clk;
  assign busy_o = busy;
  assign done_o = done;
  assign miss_o = miss;
  assign rdata_o = rdata;
endmodule
`default_nettype wire

// File: verif/ilhp_monitor.sv
// Checker of the display port wires between host and controller ends
`default_nettype none
module ilhp_monitor (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [16:0] addr,
  input wire logic [15:0] data_host,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  input wire logic display_controller_select_n,
  input wire logic memory_read_strobe_n,
  input wire logic memory_write_strobe_n,
  input wire logic wide_transfer_ack_n,
  input wire logic ready,
  input wire logic link_clk,
  input wire logic generic16
);
  // ****************************************************************
  // Wire checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  // Either strobe low
  wire logic strobe = !memory_read_strobe_n || !memory_write_strobe_n;
  wire logic sel = !display_controller_select_n;
  a_strobe_needs_select: assert property (strobe |-> sel)
    else $error("strobe without select");
  a_one_strobe_only: assert property (!(!memory_read_strobe_n && !memory_write_strobe_n))
    else $error("read and write strobes together");
  a_write_data_held: assert property (!memory_write_strobe_n |-> data_host_oe && $stable(data_host))
    else $error("write data not driven steady");
  a_no_bus_fight: assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive data");
  a_addr_held: assert property (sel && !$past(display_controller_select_n) |-> $stable(addr))
    else $error("address moved in cycle");
  a_wait_in_cycle: assert property ($fell(ready) |-> sel)
    else $error("wait outside a cycle");
  a_wait_bounded: assert property ($fell(ready) |-> ##[1:60] ready)
    else $error("wait never released");
  a_wide_ack_given: assert property ((sel && generic16) [*4] |-> !wide_transfer_ack_n)
    else $error("no wide acknowledge");
  a_no_wait_unstrapped: assert property (!generic16 |-> ready && wide_transfer_ack_n)
    else $error("unstrapped controller answered");
  // Divider makes a sixteen cycle link period
  a_link_half_period: assert property ($changed(link_clk) |-> ##8 $changed(link_clk))
    else $error("link clock period wrong");
  // Main scenarios reached
  cover property (!memory_write_strobe_n && !ready);
  cover property (!memory_read_strobe_n && data_dev_oe);
  cover property ($rose(ready) && sel);
endmodule
`default_nettype wire

// File: verif/isa_lcd_host_port_bench.sv
// Bench: host and controller ends joined, driven from both user sides
`default_nettype none
module isa_lcd_host_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_i = 1'b0;
  logic req_write_i = 1'b0;
  logic req_wide_i = 1'b0;
  logic [31:0] req_addr_i = 32'h0;
  logic [15:0] req_wdata_i = 16'h0;
  logic [3:0] strap_i = 4'hF;
  logic bus_status_strap_n_i = 1'b1;
  logic user_ack_i = 1'b0;
  logic [15:0] user_rdata_i = 16'h0;
  logic busy_o, done_o, miss_o, generic16_o, user_wr_o, user_rd_o, got_wr;
  logic [15:0] rdata_o, user_wdata_o, got_wd;
  logic [16:0] user_addr_o, got_addr;
  logic [1:0] user_lane_o, got_lane;
  int n_fail = 0;
  int samples_checked = 0;
  int n_acc = 0;
  int cyc = 0;
  bit seen_miss;
  ilhp_if bus ();
  // ****************************************************************
  // Ends under test and checker
  // ****************************************************************
  ilhp_host u_ilhp_host (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(bus), .req_i(req_i),
    .req_write_i(req_write_i), .req_wide_i(req_wide_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o), .miss_o(miss_o),
    .rdata_o(rdata_o));
  ilhp_dev u_ilhp_dev (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus(bus), .strap_i(strap_i),
    .bus_status_strap_n_i(bus_status_strap_n_i), .generic16_o(generic16_o),
    .user_addr_o(user_addr_o), .user_wdata_o(user_wdata_o), .user_lane_o(user_lane_o),
    .user_wr_o(user_wr_o), .user_rd_o(user_rd_o), .user_ack_i(user_ack_i),
    .user_rdata_i(user_rdata_i));
  ilhp_monitor u_ilhp_monitor (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr(bus.addr),
    .data_host(bus.data_host), .data_host_oe(bus.data_host_oe),
    .data_dev_oe(bus.data_dev_oe), .ready(bus.ready), .link_clk(bus.link_clk),
    .display_controller_select_n(bus.display_controller_select_n),
    .memory_read_strobe_n(bus.memory_read_strobe_n),
    .memory_write_strobe_n(bus.memory_write_strobe_n),
    .wide_transfer_ack_n(bus.wide_transfer_ack_n), .generic16(generic16_o));
  // Clock
  always #4 mclk_i = ~mclk_i;
  // Controller user side acks at once; pre-edge values are read, so no race
  always @(posedge mclk_i)
  begin
    user_ack_i <= 1'b0;
    if ((user_rd_o || user_wr_o) && !user_ack_i)
    begin
      user_ack_i <= 1'b1;
      got_wr <= user_wr_o;
      got_addr <= user_addr_o;
      got_wd <= user_wdata_o;
      got_lane <= user_lane_o;
      n_acc <= n_acc + 1;
    end
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok)
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic rst(input logic [3:0] s, input logic b);
    strap_i <= s;
    bus_status_strap_n_i <= b;
    nrst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask
  // One host transfer; gap after lets the controller see strobes released
  task automatic xfer(input logic wr, input logic wd, input logic [31:0] a,
    input logic [15:0] d);
    int n;
    bit saw_busy;
    saw_busy = 1'b0;
    req_i <= 1'b1;
    req_write_i <= wr;
    req_wide_i <= wd;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(posedge mclk_i);
    req_i <= 1'b0;
    for (n = 0; n < 300; n++)
    begin
      @(posedge mclk_i);
      saw_busy |= (busy_o === 1'b1);
      if (done_o === 1'b1 || miss_o === 1'b1)
        break;
    end
    seen_miss = (miss_o === 1'b1);
    chk(n < 300, "transfer never ended");
    chk((saw_busy || seen_miss) && busy_o === 1'b0, "busy flag");
    repeat (4) @(posedge mclk_i);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_write();
    xfer(1'b1, 1'b1, 32'h133F_FFFE, 16'hA55A);
    chk(got_wr === 1'b1 && got_addr === 17'h1FFFE, "write offset");
    chk(got_wd === 16'hA55A && got_lane === 2'b11, "write word");
  endtask
  task automatic t_read();
    user_rdata_i <= 16'h5AC3;
    xfer(1'b0, 1'b1, 32'h133E_0004, 16'h0000);
    chk(got_wr === 1'b0 && got_addr === 17'h00004, "read offset");
    chk(rdata_o === 16'h5AC3, "read word");
  endtask
  task automatic t_byte();
    xfer(1'b1, 1'b0, 32'h133E_0010, 16'h00C3);
    chk(got_lane === 2'b01 && got_wd[7:0] === 8'hC3, "byte lane");
    user_rdata_i <= 16'hBEEF;
    xfer(1'b0, 1'b0, 32'h133E_0012, 16'h0000);
    chk(got_wr === 1'b0 && got_lane === 2'b01 && got_addr === 17'h00012, "byte read");
    chk(rdata_o === 16'h00EF, "byte read data");
  endtask
  task automatic t_miss();
    int k;
    k = n_acc;
    xfer(1'b1, 1'b1, 32'h1340_0000, 16'h1234);
    chk(seen_miss && n_acc == k, "above window taken");
    xfer(1'b0, 1'b1, 32'h133D_FFFE, 16'h0000);
    chk(seen_miss && n_acc == k, "below window taken");
  endtask
  task automatic t_strap();
    int k;
    rst(4'hB, 1'b1);
    chk(generic16_o === 1'b0, "strap two low");
    rst(4'hF, 1'b0);
    chk(generic16_o === 1'b0, "status strap low");
    k = n_acc;
    xfer(1'b1, 1'b1, 32'h133E_0000, 16'h1234);
    chk(n_acc == k && !seen_miss, "unstrapped cycle taken");
    rst(4'hF, 1'b1);
    chk(generic16_o === 1'b1, "generic mode");
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst(4'hF, 1'b1);
    t_write();
    t_read();
    t_byte();
    t_miss();
    t_strap();
    t_write();
    end_of_test();
  end
endmodule
`default_nettype wire
